// ===== cies_addsub.sv
// 32-bit adder/subtractor with carry and overflow
module cies_addsub #(
	parameter int W = 32
) (
	// operands
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         sub,
	// result
	output logic      [W-1:0] sum,
	output logic              cy,
	output logic              ov
);
	logic [W-1:0] bb;
	logic         c;

	always_comb begin
		bb = sub ? ~b : b;
		{c, sum} = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, sub};
		// carry of a subtraction reads as borrow
		cy = c ^ sub;
		ov = (a[W-1] == bb[W-1]) && (sum[W-1] != a[W-1]);
	end
endmodule

// ===== cies_exec.sv
// execute unit for a subset of a 32-bit core's instructions
// Functional notes
// - register add writes sum to second register, updates carry, overflow, sign, zero
// - short add sign-extends 5-bit immediate, adds into destination, updates four flags
// - immediate add sign-extends 16 bits, adds first register, writes second
// - register AND writes second register, clears overflow, keeps carry
// - immediate AND zero-extends 16 bits, clears overflow, updates sign and zero
// - branch on condition adds shifted sign-extended 8-bit displacement, flags kept
// - halfword byte swap writes destination, clears overflow, updates carry sign zero
// - word byte reversal writes destination, clears overflow, updates carry sign zero
// - table call jumps via table base plus 6-bit index, flags kept
// - bit clear at register plus 16-bit displacement, updates only zero
// - register bit clear uses first register address, low 3 bits select
// - register conditional move picks first or second register, flags kept
// - immediate conditional move picks sign-extended 5-bit immediate or second register
// - register compare subtracts first from second, sets four flags only
// - immediate compare subtracts sign-extended immediate, sets four flags only
// - table call return restores pc and status word from save registers
// - debug trap saves pc and status word, jumps to fixed handler address
// - interrupt disable sets flag, blocking interrupts already in its own cycle
// - frame release adds scaled immediate to stack pointer, pops listed registers
// - interrupt enable clears flag, interrupts accepted from next instruction
//
// The address map and the plain strobed port were left to the implementer.
module cies_exec
	import cies_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// instruction issue from decode
	input  wire logic        issue,
	input  wire cies_op_e    op,
	input  wire logic [2:0]  ilen,
	input  wire logic [3:0]  cond,
	input  wire logic [2:0]  bit_num,
	input  wire logic [15:0] imm,
	input  wire logic [31:0] reg1_val,
	input  wire logic [31:0] reg2_val,
	input  wire logic [4:0]  dst_idx,
	input  wire logic [11:0] pop_list,
	// completion and register file write
	output logic             busy_q,
	output logic             done_q,
	output logic             rf_we_q,
	output logic      [4:0]  rf_waddr_q,
	output logic      [31:0] rf_wdata_q,
	// data memory
	output logic             mem_rd_q,
	output logic             mem_wr_q,
	output logic      [1:0]  mem_size_q,
	output logic      [31:0] mem_addr_q,
	output logic      [7:0]  mem_wdata_q,
	input  wire logic [31:0] mem_rdata,
	// core state and interrupt acceptance
	output logic      [31:0] pc_q,
	output logic      [5:0]  psw_q,
	input  wire logic        irq_req,
	output logic             irq_take_q,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_q
);
	typedef enum {S_IDLE, S_RD_WAIT, S_RD_DATA, S_POP} cies_state_e;

	cies_state_e state_q;
	cies_op_e    op_q;
	logic [31:0] call_table_base_pointer_q, ctpc_q, dbpc_q, sp_q;
	logic [5:0]  ctpsw_q, dbpsw_q;
	logic [11:0] list_q;
	logic [4:0]  pop_idx_q;
	logic [2:0]  bit_q;
	logic        go;
	logic [31:0] sx5, sx16, zx16, sx9, pc_seq;
	logic [31:0] add_a, add_b, add_s, sub_b, sub_s, byte_swap_halfword, byte_swap_word;
	logic        add_cy, add_ov, sub_cy, sub_ov, cond_ok;
	logic        wr_en;
	logic [31:0] wr_data;
	logic [3:0]  f_upd, f_val;
	logic [3:0]  pop_bit;
	logic [7:0]  clr_byte;

	function automatic logic cies_cond(input logic [3:0] cc, input logic [5:0] p);
		logic r;
		r = 1'b0;
		case (cc[2:0])
			3'h0: r = p[PSW_OV];
			3'h1: r = p[PSW_CY];
			3'h2: r = p[PSW_Z];
			3'h3: r = p[PSW_CY] | p[PSW_Z];
			3'h4: r = p[PSW_S];
			3'h5: r = 1'b1;
			3'h6: r = p[PSW_S] ^ p[PSW_OV];
			3'h7: r = (p[PSW_S] ^ p[PSW_OV]) | p[PSW_Z];
			default: r = 1'b0;
		endcase
		// the one code whose upper half is not a negation tests saturation
		if (cc == COND_SAT) begin
			r = p[PSW_SAT];
		end else if (cc[3]) begin
			r = ~r;
		end
		return r;
	endfunction

	function automatic logic [3:0] cies_low_bit(input logic [11:0] l);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (l[i]) begin
				n = 4'(i);
			end
		end
		return n;
	endfunction

	assign go = issue && (state_q == S_IDLE);

	always_comb begin
		sx5    = {{27{imm[4]}}, imm[4:0]};
		sx16   = {{16{imm[15]}}, imm};
		zx16   = {16'h0000, imm};
		sx9    = {{23{imm[7]}}, imm[7:0], 1'b0};
		pc_seq = pc_q + {29'h0, ilen};
		add_a  = (op == OP_ADD_I16) ? reg1_val : reg2_val;
		add_b  = (op == OP_ADD_RR) ? reg1_val : ((op == OP_ADD_I5) ? sx5 : sx16);
		sub_b  = (op == OP_CMP_R) ? reg1_val : sx5;
		byte_swap_halfword    = {reg2_val[23:16], reg2_val[31:24], reg2_val[7:0], reg2_val[15:8]};
		byte_swap_word    = {reg2_val[7:0], reg2_val[15:8], reg2_val[23:16], reg2_val[31:24]};
		cond_ok = cies_cond(cond, psw_q);
		pop_bit = cies_low_bit(list_q);
		clr_byte = mem_rdata[7:0] & ~(8'h01 << bit_q);
	end

	cies_addsub #(.W(32)) u_add (
		.a   (add_a),
		.b   (add_b),
		.sub (1'b0),
		.sum (add_s),
		.cy  (add_cy),
		.ov  (add_ov)
	);

	cies_addsub #(.W(32)) u_cmp (
		.a   (reg2_val),
		.b   (sub_b),
		.sub (1'b1),
		.sum (sub_s),
		.cy  (sub_cy),
		.ov  (sub_ov)
	);

	// result and flag selection; f_upd/f_val order is carry, overflow, sign, zero
	always_comb begin
		wr_en   = 1'b0;
		wr_data = 32'h0000_0000;
		f_upd   = 4'h0;
		f_val   = 4'h0;
		case (op)
			OP_ADD_RR, OP_ADD_I5, OP_ADD_I16: begin
				wr_en   = 1'b1;
				wr_data = add_s;
				f_upd   = 4'hF;
				f_val   = {add_cy, add_ov, add_s[31], add_s == 32'h0};
			end
			OP_AND_RR, OP_AND_I16: begin
				wr_en   = 1'b1;
				wr_data = reg1_val & ((op == OP_AND_RR) ? reg2_val : zx16);
				f_upd   = 4'h7;
				f_val   = {1'b0, 1'b0, wr_data[31], wr_data == 32'h0};
			end
			OP_BSH: begin
				wr_en   = 1'b1;
				wr_data = byte_swap_halfword;
				f_upd   = 4'hF;
				f_val   = {(byte_swap_halfword[7:0] == 8'h00) || (byte_swap_halfword[15:8] == 8'h00), 1'b0, byte_swap_halfword[31],
					byte_swap_halfword[15:0] == 16'h0000};
			end
			OP_BSW: begin
				wr_en   = 1'b1;
				wr_data = byte_swap_word;
				f_upd   = 4'hF;
				f_val   = {(byte_swap_word[7:0] == 8'h00) || (byte_swap_word[15:8] == 8'h00) ||
					(byte_swap_word[23:16] == 8'h00) || (byte_swap_word[31:24] == 8'h00), 1'b0, byte_swap_word[31],
					byte_swap_word == 32'h0};
			end
			OP_CONDITIONAL_MOVE_R, OP_CONDITIONAL_MOVE_I: begin
				wr_en   = 1'b1;
				wr_data = cond_ok ? ((op == OP_CONDITIONAL_MOVE_R) ? reg1_val : sx5) : reg2_val;
			end
			OP_CMP_R, OP_CMP_I: begin
				f_upd   = 4'hF;
				f_val   = {sub_cy, sub_ov, sub_s[31], sub_s == 32'h0};
			end
			default: begin
				wr_en   = 1'b0;
			end
		endcase
	end

	// program_status_word; instruction updates win over a software write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			psw_q <= PSW_RST;
		end else begin
			if (reg_wr && reg_addr == OFS_PSW) begin
				psw_q <= reg_wdata[5:0];
			end
			if (go) begin
				for (int i = 0; i < 4; i++) begin
					if (f_upd[i]) begin
						psw_q[i] <= f_val[i];
					end
				end
				case (op)
					OP_TCRET:  psw_q <= ctpsw_q;
					OP_DEBUG_RETURN:  psw_q <= dbpsw_q;
					OP_DI:     psw_q[PSW_ID] <= 1'b1;
					OP_EI:     psw_q[PSW_ID] <= 1'b0;
					default:   ;
				endcase
			end else if (state_q == S_RD_DATA && op_q != OP_TCALL && op_q != OP_FREL) begin
				psw_q[PSW_Z] <= ~mem_rdata[bit_q];
			end
		end
	end

	// program counter
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= PC_RST;
		end else if (go) begin
			case (op)
				OP_BCOND:  pc_q <= cond_ok ? pc_q + sx9 : pc_seq;
				OP_TCALL:  pc_q <= pc_q;
				OP_TCRET:  pc_q <= ctpc_q;
				OP_DEBUG_RETURN:  pc_q <= dbpc_q;
				OP_DEBUG_TRAP: pc_q <= DBG_VEC;
				default:   pc_q <= pc_seq;
			endcase
		end else if (state_q == S_RD_DATA && op_q == OP_TCALL) begin
			pc_q <= call_table_base_pointer_q + {16'h0000, mem_rdata[15:0]};
		end
	end

	// save registers and table base
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			call_table_base_pointer_q  <= CALL_TABLE_BASE_POINTER_RST;
			ctpc_q  <= PC_RST;
			ctpsw_q <= PSW_RST;
			dbpc_q  <= PC_RST;
			dbpsw_q <= PSW_RST;
		end else begin
			if (reg_wr && reg_addr == OFS_CALL_TABLE_BASE_POINTER) begin
				call_table_base_pointer_q <= {reg_wdata[31:1], 1'b0};
			end
			if (go && op == OP_TCALL) begin
				ctpc_q  <= pc_seq;
				ctpsw_q <= psw_q;
			end
			if (go && op == OP_DEBUG_TRAP) begin
				dbpc_q  <= pc_seq;
				dbpsw_q <= psw_q;
			end
		end
	end

	// sequencer for memory-touching instructions
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= S_IDLE;
			op_q        <= OP_NOP;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			mem_rd_q    <= 1'b0;
			mem_wr_q    <= 1'b0;
			mem_size_q  <= SZ_BYTE;
			mem_addr_q  <= 32'h0000_0000;
			mem_wdata_q <= 8'h00;
			sp_q        <= 32'h0000_0000;
			list_q      <= 12'h000;
			pop_idx_q   <= 5'h00;
			bit_q       <= 3'h0;
		end else begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			done_q   <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (go) begin
						op_q <= op;
						case (op)
							OP_BCLR_D, OP_BCLR_R: begin
								mem_rd_q   <= 1'b1;
								mem_size_q <= SZ_BYTE;
								mem_addr_q <= (op == OP_BCLR_D) ? reg1_val + sx16 : reg1_val;
								bit_q      <= (op == OP_BCLR_D) ? bit_num : reg2_val[2:0];
								busy_q     <= 1'b1;
								state_q    <= S_RD_WAIT;
							end
							OP_TCALL: begin
								mem_rd_q   <= 1'b1;
								mem_size_q <= SZ_HALF;
								mem_addr_q <= call_table_base_pointer_q + {25'h0, imm[5:0], 1'b0};
								busy_q     <= 1'b1;
								state_q    <= S_RD_WAIT;
							end
							OP_FREL: begin
								sp_q    <= reg1_val + {25'h0, imm[4:0], 2'b00};
								list_q  <= pop_list;
								busy_q  <= 1'b1;
								state_q <= S_POP;
							end
							default: begin
								done_q <= 1'b1;
							end
						endcase
					end
				end
				S_RD_WAIT: begin
					state_q <= S_RD_DATA;
				end
				S_RD_DATA: begin
					if (op_q == OP_FREL) begin
						state_q <= S_POP;
					end else begin
						if (op_q != OP_TCALL) begin
							mem_wr_q    <= 1'b1;
							mem_wdata_q <= clr_byte;
						end
						done_q  <= 1'b1;
						busy_q  <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				S_POP: begin
					if (list_q == 12'h000) begin
						done_q  <= 1'b1;
						busy_q  <= 1'b0;
						state_q <= S_IDLE;
					end else begin
						mem_rd_q          <= 1'b1;
						mem_size_q        <= SZ_WORD;
						mem_addr_q        <= sp_q;
						sp_q              <= sp_q + POP_STEP;
						pop_idx_q         <= POP_BASE + {1'b0, pop_bit};
						list_q[pop_bit]   <= 1'b0;
						state_q           <= S_RD_WAIT;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// register file write port
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rf_we_q    <= 1'b0;
			rf_waddr_q <= 5'h00;
			rf_wdata_q <= 32'h0000_0000;
		end else begin
			rf_we_q <= 1'b0;
			if (go && wr_en) begin
				rf_we_q    <= 1'b1;
				rf_waddr_q <= dst_idx;
				rf_wdata_q <= wr_data;
			end else if (state_q == S_RD_DATA && op_q == OP_FREL) begin
				rf_we_q    <= 1'b1;
				rf_waddr_q <= pop_idx_q;
				rf_wdata_q <= mem_rdata;
			end else if (state_q == S_POP && list_q == 12'h000) begin
				rf_we_q    <= 1'b1;
				rf_waddr_q <= SP_IDX;
				rf_wdata_q <= sp_q;
			end
		end
	end

	// interrupt acceptance only between instructions
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_take_q <= 1'b0;
		end else begin
			// a disable issued this cycle blocks at once; an enable only acts once its
			// flag update has landed, i.e. from the following instruction
			irq_take_q <= irq_req && (state_q == S_IDLE) && !psw_q[PSW_ID] &&
				!(issue && op == OP_DI);
		end
	end

	// register port reads
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_PSW:  reg_rdata_q <= {26'h0, psw_q};
				OFS_CALL_TABLE_BASE_POINTER: reg_rdata_q <= call_table_base_pointer_q;
				OFS_PC:   reg_rdata_q <= pc_q;
				default:  reg_rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_rmw;
		mem_rd_q ##1 (!mem_wr_q && !done_q) ##1 (mem_wr_q && done_q);
	endsequence

	AST_ADD_ZERO: assert property (go && op == OP_ADD_RR && !reg_wr |=>
		rf_we_q && psw_q[PSW_Z] == (rf_wdata_q == 32'h0))
		else $error("add zero flag does not match result");
	AST_AND_CY: assert property (go && op == OP_AND_RR && !reg_wr |=>
		!psw_q[PSW_OV] && psw_q[PSW_CY] == $past(psw_q[PSW_CY]))
		else $error("and changed carry or left overflow set");
	AST_BR_FLAGS: assert property (go && op == OP_BCOND && !reg_wr |=>
		psw_q == $past(psw_q))
		else $error("branch altered flags");
	AST_BCLR_SEQ: assert property (go && op == OP_BCLR_R |=> s_rmw)
		else $error("bit clear read-modify-write out of sequence");
	AST_CMP_NOWR: assert property (go && (op == OP_CMP_R || op == OP_CMP_I) |=>
		!rf_we_q)
		else $error("compare wrote a register");
	AST_TCRET: assert property (go && op == OP_TCRET |=>
		pc_q == $past(ctpc_q) && psw_q == $past(ctpsw_q))
		else $error("table call return did not restore");
	AST_DEBUG_TRAP: assert property (go && op == OP_DEBUG_TRAP && !reg_wr |=>
		pc_q == DBG_VEC && dbpsw_q == $past(psw_q) && psw_q == $past(psw_q))
		else $error("debug trap vector or save wrong");
	AST_DI_BLOCK: assert property (issue && op == OP_DI |=> !irq_take_q)
		else $error("interrupt taken during disable");
	AST_EI_NEXT: assert property (go && op == OP_EI && !reg_wr |=>
		!psw_q[PSW_ID] && !irq_take_q)
		else $error("enable acted in its own cycle");
	AST_CONDITIONAL_MOVE: assert property (go && op == OP_CONDITIONAL_MOVE_R && !cond_ok |=>
		rf_wdata_q == $past(reg2_val) && psw_q[3:0] == $past(psw_q[3:0]))
		else $error("conditional move picked wrong source");
endmodule

// ===== cies_mem_model.sv
// data memory partner: read data valid only in the cycle after the read strobe
module cies_mem_model (
	// clock
	input  wire logic        mclk,
	// memory side of the execute unit
	input  wire logic        mem_rd_q,
	input  wire logic [31:0] mem_addr_q,
	output logic      [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        rd_dly;
	logic [31:0] a1;
	logic [31:0] noise;
	initial begin
		rd_dly = 1'b0;
		noise  = 32'h0;
	end
	// the unit samples read data at the end of the cycle after its strobe, so the
	// answer must stand in exactly that cycle, not one later
	always @(posedge mclk) begin
		rd_dly <= mem_rd_q;
		a1     <= mem_addr_q;
		noise  <= noise + 32'h9E37_79B9;
	end
	// byte replicated in every lane so any lane choice reads the same value;
	// outside the valid cycle the bus churns so stale data never matches
	assign mem_rdata = rd_dly ? {4{a1[7:0] ^ 8'h5A}} : noise;
endmodule

// ===== cies_pkg.sv
// shared constants and types for the instruction execute subset
package cies_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD_RR, OP_ADD_I5, OP_ADD_I16, OP_AND_RR, OP_AND_I16, OP_BCOND,
		OP_BSH, OP_BSW, OP_TCALL, OP_BCLR_D, OP_BCLR_R, OP_CONDITIONAL_MOVE_R, OP_CONDITIONAL_MOVE_I,
		OP_CMP_R, OP_CMP_I, OP_TCRET, OP_DEBUG_RETURN, OP_DEBUG_TRAP, OP_DI, OP_EI, OP_FREL
	} cies_op_e;
	// program_status_word bit positions
	localparam int PSW_Z   = 0;
	localparam int PSW_S   = 1;
	localparam int PSW_OV  = 2;
	localparam int PSW_CY  = 3;
	localparam int PSW_SAT = 4;
	localparam int PSW_ID  = 5;
	localparam logic [5:0]  PSW_RST   = 6'h20;
	localparam logic [31:0] DBG_VEC   = 32'h0000_0060;
	localparam logic [31:0] PC_RST    = 32'h0000_0000;
	localparam logic [31:0] CALL_TABLE_BASE_POINTER_RST  = 32'h0000_0000;
	localparam logic [3:0]  COND_SAT  = 4'hD;
	localparam logic [4:0]  SP_IDX    = 5'h03;
	localparam logic [4:0]  POP_BASE  = 5'h14;
	localparam logic [31:0] POP_STEP  = 32'h0000_0004;
	// memory access sizes
	localparam logic [1:0]  SZ_BYTE   = 2'h0;
	localparam logic [1:0]  SZ_HALF   = 2'h1;
	localparam logic [1:0]  SZ_WORD   = 2'h2;
	// register port offsets
	localparam logic [7:0]  OFS_PSW   = 8'h00;
	localparam logic [7:0]  OFS_CALL_TABLE_BASE_POINTER  = 8'h04;
	localparam logic [7:0]  OFS_PC    = 8'h08;
endpackage

// ===== test_cpu_instruction_execute_subset.sv
// self-checking bench for the instruction execute subset
module test_cpu_instruction_execute_subset
	import cies_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [4:0]  wa;
		logic        we;
		logic [31:0] wd;
		logic [5:0]  program_status_word;
		logic [31:0] pc;
		logic        mw;
		logic [7:0]  md;
	} cies_exp_s;
	logic        mclk, resetn, issue, irq_req, reg_wr, reg_rd, rd_dly;
	cies_op_e    op;
	logic [2:0]  ilen, bit_num;
	logic [3:0]  cond;
	logic [15:0] imm;
	logic [31:0] reg1_val, reg2_val, reg_wdata, mem_rdata, rf_wdata_q, mem_addr_q;
	logic [31:0] pc_q, reg_rdata_q, pc, call_table_base_pointer, tc_pc, db_pc, a, b;
	logic [4:0]  dst_idx, rf_waddr_q;
	logic [11:0] pop_list;
	logic [7:0]  reg_addr, mem_wdata_q;
	logic        busy_q, done_q, rf_we_q, mem_rd_q, mem_wr_q, irq_take_q;
	logic [1:0]  mem_size_q;
	logic [5:0]  psw_q, program_status_word, tc_psw, db_psw;
	cies_exp_s   eq[$];
	logic [31:0] rq[$];
	logic [36:0] pq[$], pw;
	cies_exp_s   e, g;
	int          error_cnt, checks_done, cyc;
	// no multiply is ever issued, so the multiply operand pairing limit is kept
	cies_op_e    ops[22] = '{OP_ADD_RR, OP_ADD_I5, OP_ADD_I16, OP_AND_RR, OP_AND_I16, OP_BCOND,
		OP_BSH, OP_BSW, OP_DEBUG_TRAP, OP_CONDITIONAL_MOVE_R, OP_DEBUG_RETURN, OP_TCALL, OP_CONDITIONAL_MOVE_I, OP_TCRET,
		OP_BCLR_D, OP_BCLR_R, OP_CMP_R, OP_CMP_I, OP_DI, OP_EI, OP_FREL, OP_NOP};

	cies_exec u_dut (.mclk, .resetn, .issue, .op, .ilen, .cond, .bit_num, .imm, .reg1_val,
		.reg2_val, .dst_idx, .pop_list, .busy_q, .done_q, .rf_we_q, .rf_waddr_q, .rf_wdata_q,
		.mem_rd_q, .mem_wr_q, .mem_size_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .pc_q,
		.psw_q, .irq_req, .irq_take_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
	cies_mem_model u_mem (.mclk, .mem_rd_q, .mem_addr_q, .mem_rdata);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic cnd(input logic [3:0] c, input logic [5:0] p);
		logic v;
		case (c[2:0])
			3'h0: v = p[PSW_OV];
			3'h1: v = p[PSW_CY];
			3'h2: v = p[PSW_Z];
			3'h3: v = p[PSW_CY] | p[PSW_Z];
			3'h4: v = p[PSW_S];
			3'h5: v = 1'b1;
			3'h6: v = p[PSW_S] ^ p[PSW_OV];
			default: v = (p[PSW_S] ^ p[PSW_OV]) | p[PSW_Z];
		endcase
		return (c == COND_SAT) ? p[PSW_SAT] : v ^ c[3];
	endfunction

	// a zero byte is forced now and then so the byte-swap carry case occurs
	function automatic logic [31:0] rv();
		logic [31:0] v;
		v = $urandom;
		if ($urandom_range(0, 2) == 0)
			v = v & ~(32'hFF << (8 * $urandom_range(0, 3)));
		return v;
	endfunction

	task automatic rwr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= ad;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rrd(input logic [7:0] ad, input logic [31:0] x);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		rq.push_back(x);
		@(posedge mclk);
		reg_rd   <= 1'b0;
	endtask

	task automatic ex(input cies_op_e o, input logic [3:0] c, input logic [31:0] x1, x2);
		logic [15:0] im;
		logic [2:0]  il, bs;
		logic [32:0] r;
		logic [31:0] base, opd, x;
		logic [11:0] pl;
		logic        sub;
		int          n;
		im = 16'($urandom);
		il = 3'($urandom_range(1, 2) * 2);
		bs = (o == OP_BCLR_R) ? x2[2:0] : 3'($urandom);
		pl = 12'($urandom) & 12'h00F;
		e.wa = 5'($urandom);
		e.we = 1'b0;
		e.wd = 32'h0;
		e.program_status_word = program_status_word;
		e.pc = pc + 32'(il);
		e.mw = 1'b0;
		e.md = 8'h0;
		base = (o == OP_ADD_I16) ? x1 : x2;
		opd = (o == OP_ADD_RR || o == OP_CMP_R) ? x1 :
			(o == OP_ADD_I16) ? {{16{im[15]}}, im} : {{27{im[4]}}, im[4:0]};
		sub = (o == OP_CMP_R || o == OP_CMP_I);
		r = sub ? {1'b0, base} - {1'b0, opd} : {1'b0, base} + {1'b0, opd};
		case (o)
			OP_ADD_RR, OP_ADD_I5, OP_ADD_I16, OP_CMP_R, OP_CMP_I: begin
				e.we = !sub;
				e.wd = r[31:0];
				e.program_status_word[3:0] = {r[32], (sub ? base[31] != opd[31] : base[31] == opd[31])
					&& r[31] != base[31], r[31], r[31:0] == 32'h0};
			end
			OP_AND_RR, OP_AND_I16: begin
				x = x1 & ((o == OP_AND_RR) ? x2 : {16'h0, im});
				e.we = 1'b1;
				e.wd = x;
				e.program_status_word[2:0] = {1'b0, x[31], x == 32'h0};
			end
			OP_BSH, OP_BSW: begin
				x = (o == OP_BSH) ? {x2[23:16], x2[31:24], x2[7:0], x2[15:8]}
					: {x2[7:0], x2[15:8], x2[23:16], x2[31:24]};
				e.we = 1'b1;
				e.wd = x;
				e.program_status_word[3:0] = {x[7:0] == 8'h0 || x[15:8] == 8'h0 || (o == OP_BSW &&
					(x[23:16] == 8'h0 || x[31:24] == 8'h0)), 1'b0, x[31],
					(o == OP_BSH) ? x[15:0] == 16'h0 : x == 32'h0};
			end
			OP_CONDITIONAL_MOVE_R, OP_CONDITIONAL_MOVE_I: begin
				e.we = 1'b1;
				e.wd = !cnd(c, program_status_word) ? x2 : (o == OP_CONDITIONAL_MOVE_R) ? x1 : {{27{im[4]}}, im[4:0]};
			end
			OP_BCOND: if (cnd(c, program_status_word)) e.pc = pc + {{23{im[7]}}, im[7:0], 1'b0};
			OP_DEBUG_TRAP: begin
				db_pc = e.pc;
				db_psw = program_status_word;
				e.pc = DBG_VEC;
			end
			OP_DEBUG_RETURN: begin
				e.pc = db_pc;
				e.program_status_word = db_psw;
			end
			OP_TCALL: begin
				x = call_table_base_pointer + {25'h0, im[5:0], 1'b0};
				tc_pc = e.pc;
				tc_psw = program_status_word;
				e.pc = call_table_base_pointer + {16'h0, {2{x[7:0] ^ 8'h5A}}};
			end
			OP_TCRET: begin
				e.pc = tc_pc;
				e.program_status_word = tc_psw;
			end
			OP_BCLR_D, OP_BCLR_R: begin
				x = (o == OP_BCLR_D) ? x1 + {{16{im[15]}}, im} : x1;
				e.mw = 1'b1;
				e.md = (x[7:0] ^ 8'h5A) & ~(8'h01 << bs);
				e.program_status_word[PSW_Z] = !(((x[7:0] ^ 8'h5A) >> bs) & 8'h01);
			end
			OP_DI: e.program_status_word[PSW_ID] = 1'b1;
			OP_EI: e.program_status_word[PSW_ID] = 1'b0;
			OP_FREL: begin
				e.we = 1'b1;
				e.wa = SP_IDX;
				x = x1 + {25'h0, im[4:0], 2'h0};
				for (int i = 0; i < 12; i++) begin
					if (pl[i]) begin
						pq.push_back({5'(POP_BASE + i), {4{x[7:0] ^ 8'h5A}}});
						x = x + 32'h0000_0004;
					end
				end
				e.wd = x;
			end
			default: ;
		endcase
		@(posedge mclk);
		issue <= 1'b1;
		op <= o;
		cond <= c;
		ilen <= il;
		bit_num <= bs;
		imm <= im;
		reg1_val <= x1;
		reg2_val <= x2;
		dst_idx <= e.wa;
		pop_list <= pl;
		eq.push_back(e);
		pc = e.pc;
		program_status_word = e.program_status_word;
		@(posedge mclk);
		issue <= 1'b0;
		#1;
		n = 0;
		while (done_q !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (done_q !== 1'b1) begin
			error_cnt++;
			$display("Error %0t: %s never completed", $time, o.name());
		end
	endtask

	always @(posedge mclk) begin
		if (resetn === 1'b1 && done_q === 1'b1) begin
			g = eq.pop_front();
			cmp32(32'(rf_we_q), 32'(g.we), "write enable");
			if (g.we) cmp32(rf_wdata_q, g.wd, "write data");
			if (g.we) cmp32(32'(rf_waddr_q), 32'(g.wa), "write index");
			if (g.mw) cmp32({mem_wr_q, mem_wdata_q}, {1'b1, g.md}, "byte write");
			cmp32(32'(psw_q), 32'(g.program_status_word), "status word");
			cmp32(pc_q, g.pc, "pc");
		end
		if (resetn === 1'b1 && rf_we_q === 1'b1 && done_q !== 1'b1) begin
			pw = pq.pop_front();
			cmp32(32'(rf_waddr_q), 32'(pw[36:32]), "pop index");
			cmp32(rf_wdata_q, pw[31:0], "pop data");
		end
		if (mem_rd_q === 1'b1) cmp32({busy_q, mem_size_q}, (op == OP_TCALL) ? {1'b1, SZ_HALF} :
			(op == OP_FREL) ? {1'b1, SZ_WORD} : {1'b1, SZ_BYTE}, "busy and access size");
		if (rd_dly === 1'b1) cmp32(reg_rdata_q, rq.pop_front(), "register read");
		rd_dly <= reg_rd;
	end

	// whole run needs a few thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		{issue, irq_req, reg_wr, reg_rd, rd_dly, resetn} = 6'h0;
		{ilen, bit_num, cond, imm, dst_idx, pop_list, reg_addr} = 51'h0;
		{reg1_val, reg2_val, reg_wdata} = 96'h0;
		op = OP_NOP;
		pc = PC_RST;
		program_status_word = PSW_RST;
		void'($urandom(48));
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		#1;
		cmp32(32'(psw_q), 32'(PSW_RST), "reset status word");
		cmp32(pc_q, PC_RST, "reset pc");
		rrd(OFS_PSW, 32'(PSW_RST));
		rwr(8'h10, $urandom);
		rrd(8'h10, 32'h0);
		call_table_base_pointer = $urandom & 32'h0000_FFFE;
		rwr(OFS_CALL_TABLE_BASE_POINTER, call_table_base_pointer | 32'h1);
		rrd(OFS_CALL_TABLE_BASE_POINTER, call_table_base_pointer);
		irq_req <= 1'b1;
		ex(OP_EI, 4'h0, 32'h0, 32'h0);
		cmp32(32'(irq_take_q), 32'h0, "accept during enable");
		@(posedge mclk);
		#1;
		cmp32(32'(irq_take_q), 32'h1, "accept after enable");
		ex(OP_DI, 4'h0, 32'h0, 32'h0);
		cmp32(32'(irq_take_q), 32'h0, "accept during disable");
		irq_req <= 1'b0;
		for (int r = 0; r < 48; r++) begin
			program_status_word[4:0] = 5'($urandom);
			rwr(OFS_PSW, 32'(program_status_word));
			foreach (ops[k]) begin
				a = rv();
				b = (ops[k] inside {OP_ADD_I5, OP_CMP_I, OP_BSH, OP_BSW}) ? a : rv();
				ex(ops[k], 4'(r), a, b);
			end
		end
		rrd(OFS_PC, pc);
		rrd(OFS_PSW, 32'(program_status_word));
		repeat (3) @(posedge mclk);
		cmp32(32'(eq.size() + pq.size()), 32'h0, "results never seen");
		end_sim();
	end
endmodule
